// ===== dmbank_pkg.sv
// Purpose: Shared constants for the system register and bank select logic
// Assumes: 7-bit data memory address, 4-bit data, 4 banks
// Notes: Offsets are data memory addresses inside the common area
package dmbank_pkg;
    localparam int DATA_W = 4;
    localparam int ADDR_W = 7;
    localparam int BANK_W = 2;
    localparam int REGFILE_ADDR_W = 7;
    localparam logic [6:0] SYS_LO = 7'h74;
    localparam logic [6:0] SYS_HI = 7'h7f;
    localparam logic [6:0] WIN_ADDR = 7'h78;
    localparam logic [6:0] BANK_ADDR = 7'h79;
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [3:0] WIN_RESET = 4'h0;
    localparam int BANK_FIELD_LSB = 0;
endpackage

// ===== dm_bus_if.sv
// Purpose: Carries the routed data memory access from top to the array
// Assumes: One access per enabled cycle
// Notes: Address already has the bank folded in
`timescale 1ns/1ps
interface dm_bus_if;
    logic we;
    logic [8:0] addr;
    logic [3:0] wdata;
    logic [3:0] rdata;
    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ===== dm_array.sv
// Purpose: Banked general data memory storage
// Assumes: Synchronous write, combinational read
// Notes: Four banks of 128 nibbles, system area locations unused here
`timescale 1ns/1ps
module dm_array (
    input wire logic i_clk,
    input wire logic i_ce,
    dm_bus_if.mem bus
);
    logic [3:0] mem [0:511];
    // Write on enabled cycles only so the clock enable freezes storage
    always_ff @(posedge i_clk) begin
        if (i_ce && bus.we) begin
            mem[bus.addr] <= bus.wdata;
        end
    end
    assign bus.rdata = mem[bus.addr];
endmodule

// ===== data_memory_bank_select.sv
// Purpose: Bank select, window register and register file transfer logic
// Assumes: CPU strobes one access or transfer per enabled cycle
// Notes: Register file storage sits outside; this block drives its port
//
// Contract
// - Store copies window register into regfile location
// - Bank select lives at system address 79H
// - Upper two bank bits read zero, ignored
// - Bank cleared by power-on, chip-enable, clock-stop
// - Four data memory banks chosen by bank
// - Memory accesses use currently selected bank
// - 74H-7FH shared system registers, bank independent
// - Bank write works identically in every bank
// - Window register at 78H, kept over chip-enable reset and clock-stop, cleared by power-on
// - Load copies regfile location into window register

`timescale 1ns/1ps

module data_memory_bank_select
    import dmbank_pkg::*;
#(
    parameter int NUM_BANKS = 4
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_ce_reset,
    input wire logic i_clock_stop,
    input wire logic i_mem_wr,
    input wire logic i_mem_rd,
    input wire logic [6:0] i_mem_addr,
    input wire logic [3:0] i_mem_wdata,
    input wire logic i_store_to_regfile,
    input wire logic i_load_from_regfile,
    input wire logic [6:0] i_regfile_location,
    input wire logic [3:0] i_regfile_rdata,
    output logic [3:0] o_mem_rdata,
    output logic o_regfile_we,
    output logic [6:0] o_regfile_addr,
    output logic [3:0] o_regfile_wdata,
    output logic [1:0] o_bank
);
    // Every flop of the block except the u_array storage lives in this one record
    typedef struct packed {
        logic [1:0] bank;
        logic [3:0] win;
        logic [3:0] rdata;
        logic regfile_we;
        logic [6:0] regfile_addr;
        logic [3:0] regfile_wdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    dm_bus_if dbus ();

    // Address falls inside the common system register area
    function automatic logic is_sys(input logic [6:0] a);
        return (a >= SYS_LO) && (a <= SYS_HI);
    endfunction

    // Only the four-bank nibble layout is wired up; refuse anything else
    if (DATA_W != 4 || BANK_W != 2 || NUM_BANKS != (1 << BANK_W)) begin : g_bad_geometry
        $error("Unsupported bank count or data width");
    end

    dm_array u_array (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .bus(dbus)
    );

    // Bank is prepended to the row address; system area never reaches the array
    assign dbus.addr = {cur.bank, i_mem_addr};
    assign dbus.we = i_mem_wr && !is_sys(i_mem_addr);
    assign dbus.wdata = i_mem_wdata;

    // Next state: decoding, transfers and bank updates
    always_comb begin
        next_cur = cur;
        next_cur.regfile_we = 1'b0; // Write pulse lasts one enabled cycle
        if (i_mem_rd) begin
            if (i_mem_addr == BANK_ADDR) begin
                next_cur.rdata = {2'b00, cur.bank};
            end else if (i_mem_addr == WIN_ADDR) begin
                next_cur.rdata = cur.win;
            end else if (is_sys(i_mem_addr)) begin
                next_cur.rdata = 4'h0; // Other system registers live elsewhere
            end else begin
                next_cur.rdata = dbus.rdata;
            end
        end
        if (i_mem_wr) begin
            // Decode ignores current bank, so the write lands the same everywhere
            if (i_mem_addr == BANK_ADDR) begin
                next_cur.bank = i_mem_wdata[1:0];
            end else if (i_mem_addr == WIN_ADDR) begin
                next_cur.win = i_mem_wdata;
            end
        end
        if (i_store_to_regfile) begin
            // Old window is stored, so a same-cycle load cannot leak into it
            next_cur.regfile_we = 1'b1;
            next_cur.regfile_addr = i_regfile_location;
            next_cur.regfile_wdata = cur.win;
        end
        if (i_load_from_regfile) begin
            next_cur.win = i_regfile_rdata;
            next_cur.regfile_addr = i_regfile_location;
        end
        // Window register is deliberately kept across these events
        if (i_ce_reset || i_clock_stop) begin
            next_cur.bank = BANK_RESET;
        end
    end

    // Power-on reset clears bank and window, and the rest of the state, to their reset values
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cur <= '{bank: BANK_RESET, win: WIN_RESET, rdata: 4'h0,
                     regfile_we: 1'b0, regfile_addr: 7'h00, regfile_wdata: 4'h0};
        end else if (i_ce) begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from the state flops, no logic after them
    assign o_mem_rdata = cur.rdata;
    assign o_regfile_we = cur.regfile_we;
    assign o_regfile_addr = cur.regfile_addr;
    assign o_regfile_wdata = cur.regfile_wdata;
    assign o_bank = cur.bank;

    // Bank register: write, read-back, clears and hold
    a_bank_write: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_wr && i_mem_addr == BANK_ADDR && !i_ce_reset && !i_clock_stop)
        |=> o_bank == $past(i_mem_wdata[1:0]))
        else $error("Bank write not taken");
    a_bank_upper_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_rd && i_mem_addr == BANK_ADDR)
        |=> o_mem_rdata == {2'b00, $past(o_bank)})
        else $error("Bank read-back wrong");
    a_bank_clear: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && (i_ce_reset || i_clock_stop)) |=> o_bank == 2'b00)
        else $error("Bank not cleared");
    a_bank_keep: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_ce_reset && !i_clock_stop && !(i_mem_wr && i_mem_addr == BANK_ADDR))
        |=> $stable(o_bank))
        else $error("Bank changed without a bank write");
    a_bank_hold: assert property ( // Clock enable freeze
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_ce) |=> $stable(o_bank))
        else $error("Bank changed while frozen");
    a_state_hold: assert property ( // Clock enable freeze
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_ce) |=> $stable(cur))
        else $error("State changed while frozen");

    // Data memory routing; the system area is common to every bank
    a_bank_route: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        dbus.addr[8:7] == o_bank)
        else $error("Bank not routed to memory");
    a_sys_no_write: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_mem_wr && i_mem_addr >= SYS_LO) |-> !dbus.we)
        else $error("System area reached memory");
    a_sys_read_zero: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_rd && is_sys(i_mem_addr) && i_mem_addr != WIN_ADDR && i_mem_addr != BANK_ADDR)
        |=> o_mem_rdata == 4'h0)
        else $error("Foreign system register read not zero");
    a_mem_read: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_rd && i_mem_addr < SYS_LO) |=> o_mem_rdata == $past(dbus.rdata))
        else $error("Banked read wrong");
    a_rdata_hold: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!(i_ce && i_mem_rd)) |=> $stable(o_mem_rdata))
        else $error("Read data changed without a read");

    // Window register: written at its address, kept over soft resets
    a_win_write: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_wr && i_mem_addr == WIN_ADDR && !i_load_from_regfile)
        |=> cur.win == $past(i_mem_wdata))
        else $error("Window write not taken");
    a_win_read: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_mem_rd && i_mem_addr == WIN_ADDR) |=> o_mem_rdata == $past(cur.win))
        else $error("Window read-back wrong");
    a_win_keep: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_ce_reset && !i_load_from_regfile && !(i_mem_wr && i_mem_addr == WIN_ADDR))
        |=> cur.win == $past(cur.win))
        else $error("Window lost on reset");
    a_win_stop: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_clock_stop && !i_load_from_regfile && !(i_mem_wr && i_mem_addr == WIN_ADDR))
        |=> cur.win == $past(cur.win))
        else $error("Window lost on clock stop");

    // Register file transfers in both directions
    a_store_regfile: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_store_to_regfile && !i_load_from_regfile)
        |=> o_regfile_we && o_regfile_wdata == $past(cur.win)
            && o_regfile_addr == $past(i_regfile_location))
        else $error("Store to register file wrong");
    a_store_pulse: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !i_store_to_regfile) |=> !o_regfile_we)
        else $error("Register file write pulse too long");
    a_regfile_hold: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (!(i_ce && (i_store_to_regfile || i_load_from_regfile)))
        |=> $stable(o_regfile_addr) && $stable(o_regfile_wdata))
        else $error("Register file port changed without a transfer");
    a_load_regfile: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_load_from_regfile) |=> cur.win == $past(i_regfile_rdata))
        else $error("Load from register file wrong");
    a_load_addr: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_load_from_regfile && !i_store_to_regfile)
        |=> o_regfile_addr == $past(i_regfile_location) && !o_regfile_we)
        else $error("Load address wrong or write raised");
endmodule

// ===== data_memory_bank_select_bench.sv
// Purpose: Self-checking bench for bank select, window and register file transfers
// Assumes: Inputs driven on falling edge, outputs settle one edge after a strobe
// Notes: Ordinary accesses come from a row table, resets and transfers by hand
`timescale 1ns/1ps
module data_memory_bank_select_bench;
    import dmbank_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, i_ce = 1, i_ce_reset = 0, i_clock_stop = 0;
    logic i_mem_wr = 0, i_mem_rd = 0, i_store_to_regfile = 0, i_load_from_regfile = 0;
    logic [6:0] i_mem_addr = 7'h00, i_regfile_location = 7'h00, o_regfile_addr;
    logic [3:0] i_mem_wdata = 4'h0, i_regfile_rdata = 4'h0, o_mem_rdata, o_regfile_wdata;
    logic o_regfile_we;
    logic [1:0] o_bank;
    int miscompares = 0, tests_run = 0;
    typedef struct {logic wr; logic [6:0] addr; logic [3:0] data; logic [1:0] bank; logic [3:0] rdata;} row_t;
    // Same offset 05 in two banks proves the bank reaches the array
    row_t rows[12] = '{'{1, 7'h79, 4'h1, 2'h1, 4'h0}, '{1, 7'h05, 4'ha, 2'h1, 4'h0},
        '{1, 7'h79, 4'h2, 2'h2, 4'h0}, '{1, 7'h05, 4'hb, 2'h2, 4'h0}, '{1, 7'h79, 4'h1, 2'h1, 4'h0},
        '{0, 7'h05, 4'h0, 2'h1, 4'ha}, '{1, 7'h79, 4'hf, 2'h3, 4'h0}, '{0, 7'h79, 4'h0, 2'h3, 4'h3},
        '{1, 7'h78, 4'h6, 2'h3, 4'h0}, '{1, 7'h79, 4'h0, 2'h0, 4'h0}, '{0, 7'h78, 4'h0, 2'h0, 4'h6},
        '{0, 7'h7a, 4'h0, 2'h0, 4'h0}};

    data_memory_bank_select data_memory_bank_select_inst (.i_clk, .i_sys_rst, .i_ce, .i_ce_reset,
        .i_clock_stop, .i_mem_wr, .i_mem_rd, .i_mem_addr, .i_mem_wdata, .i_store_to_regfile,
        .i_load_from_regfile, .i_regfile_location, .i_regfile_rdata, .o_mem_rdata, .o_regfile_we,
        .o_regfile_addr, .o_regfile_wdata, .o_bank);

    // Free-running clock, 25 ns period
    always #12.5 i_clk = ~i_clk;

    task check(input logic [6:0] seen, input logic [6:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobe, result visible after the next rising edge
    task access(input logic wr, input logic [6:0] a, input logic [3:0] d);
        @(negedge i_clk);
        i_mem_wr = wr;
        i_mem_rd = !wr;
        i_mem_addr = a;
        i_mem_wdata = d;
        @(negedge i_clk);
        i_mem_wr = 0;
        i_mem_rd = 0;
    endtask

    task results();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge i_clk);
        miscompares++;
        results();
    end

    initial begin
        repeat (4) @(negedge i_clk);
        i_sys_rst = 0;
        access(0, BANK_ADDR, 4'h0);
        check({5'h0, o_bank}, 7'h0);
        check({3'h0, o_mem_rdata}, 7'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            access(rows[i].wr, rows[i].addr, rows[i].data);
            check({5'h0, o_bank}, {5'h0, rows[i].bank});
            if (!rows[i].wr) check({3'h0, o_mem_rdata}, {3'h0, rows[i].rdata});
        end
        $display("row table done");
        // Store of window (6) to a regfile location
        @(negedge i_clk);
        i_store_to_regfile = 1;
        i_regfile_location = 7'h33;
        @(negedge i_clk);
        i_store_to_regfile = 0;
        check({6'h0, o_regfile_we}, 7'h1);
        check(o_regfile_addr, 7'h33);
        check({3'h0, o_regfile_wdata}, 7'h6);
        @(negedge i_clk);
        check({6'h0, o_regfile_we}, 7'h0);
        // Load from regfile, then read the window back
        i_load_from_regfile = 1;
        i_regfile_location = 7'h12;
        i_regfile_rdata = 4'hc;
        @(negedge i_clk);
        i_load_from_regfile = 0;
        access(0, WIN_ADDR, 4'h0);
        check({3'h0, o_mem_rdata}, 7'hc);
        $display("transfer test done");
        // Chip-enable reset clears bank but keeps window
        access(1, BANK_ADDR, 4'h2);
        i_ce_reset = 1;
        @(negedge i_clk);
        i_ce_reset = 0;
        check({5'h0, o_bank}, 7'h0);
        access(0, WIN_ADDR, 4'h0);
        check({3'h0, o_mem_rdata}, 7'hc);
        // Clock stop clears bank as well
        access(1, BANK_ADDR, 4'h3);
        i_clock_stop = 1;
        @(negedge i_clk);
        i_clock_stop = 0;
        check({5'h0, o_bank}, 7'h0);
        // Frozen clock enable must ignore a bank write
        i_ce = 0;
        access(1, BANK_ADDR, 4'h1);
        i_ce = 1;
        check({5'h0, o_bank}, 7'h0);
        // Power-on reset in mid-run
        access(1, BANK_ADDR, 4'h2);
        i_sys_rst = 1;
        @(negedge i_clk);
        i_sys_rst = 0;
        check({5'h0, o_bank}, 7'h0);
        $display("reset source test done");
        results();
    end
endmodule
